// *** rtl/pfbc_bus_control.sv ***
// parallel flash bus control: pin decode, address latch, data and wait
// assumes the array core sits on the user-side ports, same clock
module pfbc_bus_control
   import pfbc_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   // flash pins
   input wire logic die_one_select_n_in,
   input wire logic die_one_output_enable_n_in,
   input wire logic write_enable_n_in,
   input wire logic address_valid_n_in,
   input wire logic reset_n_in,
   input wire logic write_protect_n_in,
   input wire logic flash_clk_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_out,
   output logic wait_out,
   output logic wait_oe_out,
   // array core side
   input wire logic sync_mode_in,
   input wire logic [CFG_W-1:0] read_config_reg_in,
   input wire logic [DATA_W-1:0] read_data_in,
   input wire logic read_data_valid_in,
   input wire logic busy_in,
   input wire logic leave_read_array_in,
   input wire logic status_load_in,
   input wire logic [STAT_W-1:0] status_in,
   output logic [ADDR_W-1:0] read_addr_out,
   output logic top_die_out,
   output logic [ADDR_W-1:0] write_addr_out,
   output logic [DATA_W-1:0] write_data_out,
   output logic write_strobe_out,
   output logic automation_reset_out,
   output logic device_active_out,
   output logic lockdown_enforce_out,
   output logic read_array_mode_out,
   output logic [STAT_W-1:0] status_reg_out,
   output pfbc_op_e bus_op_out
);

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] pins_reg;
   wire [SYNC_W-1:0] pins_raw = {dq_in, addr_in, flash_clk_in,
      write_protect_n_in, reset_n_in, address_valid_n_in,
      write_enable_n_in, die_one_output_enable_n_in,
      die_one_select_n_in};

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         meta_reg <= SYNC_RESET;
         pins_reg <= SYNC_RESET;
      end
      else
      begin
         meta_reg <= pins_raw;
         pins_reg <= meta_reg;
      end
   end

   wire s_ce_n = pins_reg[POS_CE];
   wire s_oe_n = pins_reg[POS_OE];
   wire s_we_n = pins_reg[POS_WE];
   wire s_addr_valid_n = pins_reg[POS_ADDR_VALID];
   wire s_rst_n = pins_reg[POS_RST];
   wire s_wp_n = pins_reg[POS_WP];
   wire s_clk = pins_reg[POS_CLK];
   wire [ADDR_W-1:0] s_addr = pins_reg[POS_DATA-1:POS_ADDR];
   wire [DATA_W-1:0] s_dq = pins_reg[SYNC_W-1:POS_DATA];

   // ************************************************************
   // bus operation decode
   // ************************************************************
   logic read_array_reset_hold;
   wire in_reset = ~s_rst_n;
   wire do_read = s_rst_n & ~s_ce_n & ~s_oe_n & s_we_n;
   wire do_write = s_rst_n & ~s_ce_n & s_oe_n & ~s_we_n;
   wire drive_en = s_rst_n & ~s_ce_n & ~s_oe_n;
   wire sync_eff = sync_mode_in & ~read_array_reset_hold;
   wire wait_pol = read_config_reg_in[WAIT_POL_BIT];

   pfbc_op_e op_next;

   always_comb
   begin
      if (in_reset)
         op_next = PFBC_RESET;
      else if (s_ce_n)
         op_next = PFBC_STANDBY;
      else if (do_read)
         op_next = PFBC_READ;
      else if (do_write)
         op_next = PFBC_WRITE;
      else
         op_next = PFBC_DISABLE;
   end

   // ************************************************************
   // address latch
   // ************************************************************
   logic valid_d_reg;
   logic clk_d_reg;
   logic sync_taken_reg;
   logic [ADDR_W-1:0] addr_reg;

   wire valid_rise = s_addr_valid_n & ~valid_d_reg;
   wire clk_rise = s_clk & ~clk_d_reg;
   wire sync_ok = s_we_n & s_rst_n & ~s_ce_n;
   // async: follow pins while valid low, hold from its rising edge
   wire async_follow = ~sync_eff & ~s_addr_valid_n;
   // sync: first clock edge with valid low, unless already taken
   wire sync_take = sync_eff & sync_ok & ~s_addr_valid_n & clk_rise
      & ~sync_taken_reg;
   wire sync_valid_take = sync_eff & sync_ok & valid_rise & ~sync_taken_reg;
   wire addr_load = async_follow | sync_take | sync_valid_take;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         valid_d_reg <= 1'h1;
         clk_d_reg <= 1'h0;
         sync_taken_reg <= 1'h0;
         addr_reg <= ADDR_RESET;
      end
      else
      begin
         valid_d_reg <= s_addr_valid_n;
         clk_d_reg <= s_clk;
         if (s_addr_valid_n | ~sync_eff)
            sync_taken_reg <= 1'h0;
         else if (sync_take)
            sync_taken_reg <= 1'h1;
         if (addr_load)
            addr_reg <= s_addr;
      end
   end

   assign read_addr_out = addr_reg;
   assign top_die_out = addr_reg[DIE_SEL_BIT];

   // ************************************************************
   // write capture
   // ************************************************************
   logic wr_active_reg;
   logic wr_strobe_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [DATA_W-1:0] wr_data_reg;
   wire wr_end = wr_active_reg & s_rst_n & (s_we_n | s_ce_n);

   always_ff @(posedge clock_in)
   begin
      if (rst_in | in_reset)
      begin
         wr_active_reg <= 1'h0;
         wr_strobe_reg <= 1'h0;
      end
      else
      begin
         wr_active_reg <= do_write;
         wr_strobe_reg <= wr_end;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         wr_addr_reg <= ADDR_RESET;
         wr_data_reg <= DATA_RESET;
      end
      else if (do_write)
      begin
         wr_addr_reg <= s_addr;
         wr_data_reg <= s_dq;
      end
   end

   assign write_addr_out = wr_addr_reg;
   assign write_data_out = wr_data_reg;
   assign write_strobe_out = wr_strobe_reg;

   // ************************************************************
   // data and wait drivers
   // ************************************************************
   logic [DATA_W-1:0] dq_reg;
   wire wait_busy = sync_eff & do_read & ~read_data_valid_in;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         dq_reg <= DATA_RESET;
      else if (do_read)
         dq_reg <= read_data_in;
   end

   assign dq_out = dq_reg;
   assign dq_oe_out = do_read;
   assign wait_oe_out = drive_en;
   // asserted level equals the polarity bit, else its inverse
   assign wait_out = wait_busy ? wait_pol : ~wait_pol;

   // ************************************************************
   // mode, status and device state
   // ************************************************************
   logic [STAT_W-1:0] status_reg;
   logic read_array_reg;
   pfbc_op_e op_reg;

   always_ff @(posedge clock_in)
   begin
      if (rst_in | in_reset)
      begin
         status_reg <= STATUS_RESET;
         read_array_reg <= 1'h1;
         read_array_reset_hold <= 1'h1;
      end
      else
      begin
         read_array_reset_hold <= 1'h0;
         if (status_load_in)
            status_reg <= status_in;
         if (leave_read_array_in)
            read_array_reg <= 1'h0;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         op_reg <= PFBC_RESET;
      else
         op_reg <= op_next;
   end

   assign status_reg_out = status_reg;
   assign read_array_mode_out = read_array_reg;
   assign bus_op_out = op_reg;
   assign automation_reset_out = in_reset;
   assign device_active_out = s_rst_n & (~s_ce_n | busy_in);
   assign lockdown_enforce_out = ~s_wp_n;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   chk_die_route: assert property (
      addr_load |=> top_die_out == $past(s_addr[DIE_SEL_BIT]))
      else $error("die select does not follow high address bit");

   chk_data_float: assert property (
      (s_ce_n | s_oe_n | in_reset) |-> !dq_oe_out)
      else $error("data bus driven while not reading");

   chk_async_flow: assert property (
      (!sync_eff && !s_addr_valid_n) |=> read_addr_out == $past(s_addr))
      else $error("async address not flowing through");

   chk_sync_hold: assert property (
      (sync_taken_reg && !s_addr_valid_n && sync_eff)
      |=> $stable(read_addr_out))
      else $error("sync address changed after capture");

   chk_standby_float: assert property (
      s_ce_n |-> !wait_oe_out && !dq_oe_out ##1
      (bus_op_out == PFBC_STANDBY || bus_op_out == PFBC_RESET))
      else $error("standby outputs not floated");

   chk_wait_drive: assert property (
      wait_oe_out == (!s_ce_n && !s_oe_n && s_rst_n))
      else $error("wait driven outside select and oe low");

   chk_wait_busy: assert property (
      (sync_eff && do_read && !read_data_valid_in)
      |-> wait_out == read_config_reg_in[WAIT_POL_BIT])
      else $error("wait not asserted on invalid burst data");

   chk_wait_idle: assert property (
      (!sync_eff || do_write) |-> wait_out != wait_pol)
      else $error("wait asserted outside sync reads");

   chk_write_take: assert property (
      write_strobe_out |-> write_addr_out == $past(s_addr, 2)
      && write_data_out == $past(s_dq, 2))
      else $error("write captured wrong address or data");

   chk_reset_inhibit: assert property (
      in_reset |-> !dq_oe_out && !wait_oe_out ##1 !write_strobe_out)
      else $error("write or drive during reset");

   chk_busy_active: assert property (
      (busy_in && s_rst_n) |-> device_active_out)
      else $error("device went standby while busy");

   chk_status_init: assert property (
      (in_reset ##1 !in_reset) |-> status_reg_out == STATUS_RESET
      && read_array_mode_out)
      else $error("status or mode wrong after reset");

   cov_async_read: cover property (do_read && !sync_eff);
   cov_sync_wait: cover property (wait_busy ##1 !wait_busy && do_read);
   cov_write: cover property (do_write ##1 !do_write ##1 write_strobe_out);
   cov_reset_exit: cover property (in_reset ##1 !in_reset);

endmodule

// *** rtl/pfbc_pkg.sv ***
// parallel flash bus control: shared constants and types
// assumes one 125 MHz system clock; flash pins arrive asynchronous
package pfbc_pkg;

   // ************************************************************
   // widths and field positions
   // ************************************************************
   localparam int ADDR_W = 25;
   localparam int DATA_W = 16;
   localparam int STAT_W = 8;
   localparam int CFG_W = 16;
   localparam int DIE_SEL_BIT = 24;
   localparam int WAIT_POL_BIT = 10;
   // pins bundled for the synchroniser: ctrl bits then addr then data
   localparam int CTRL_W = 7;
   localparam int SYNC_W = CTRL_W + ADDR_W + DATA_W;
   localparam int POS_CE = 0;
   localparam int POS_OE = 1;
   localparam int POS_WE = 2;
   localparam int POS_ADDR_VALID = 3;
   localparam int POS_RST = 4;
   localparam int POS_WP = 5;
   localparam int POS_CLK = 6;
   localparam int POS_ADDR = CTRL_W;
   localparam int POS_DATA = CTRL_W + ADDR_W;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [STAT_W-1:0] STATUS_RESET = 8'h80;
   localparam logic [SYNC_W-1:0] SYNC_RESET = {{(SYNC_W-CTRL_W){1'h0}},
                                               7'h3F};
   localparam logic [ADDR_W-1:0] ADDR_RESET = 25'h0000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

   // ************************************************************
   // bus operation states
   // ************************************************************
   typedef enum logic [2:0] {
      PFBC_RESET,
      PFBC_STANDBY,
      PFBC_DISABLE,
      PFBC_READ,
      PFBC_WRITE
   } pfbc_op_e;

endpackage

// *** tb/pfbc_host_model.sv ***
// host side of the flash pins: drives the bus like a processor
// assumes tasks are entered 1 ns after a rising clock edge
module pfbc_host_model
   import pfbc_pkg::*;
(
   input wire logic clock_in,
   output logic die_one_select_n_out,
   output logic die_one_output_enable_n_out,
   output logic write_enable_n_out,
   output logic address_valid_n_out,
   output logic reset_n_out,
   output logic write_protect_n_out,
   output logic flash_clk_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic [DATA_W-1:0] dq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] last_dq;
   // ************************************************************
   // bus cycles
   // ************************************************************
   // released data lines show the inverse of the last value
   task automatic idle();
      die_one_select_n_out = 1'h1;
      die_one_output_enable_n_out = 1'h1;
      write_enable_n_out = 1'h1;
      address_valid_n_out = 1'h1;
      dq_out = ~last_dq;
   endtask
   task automatic read_start(input logic [ADDR_W-1:0] a);
      addr_out = a;
      write_enable_n_out = 1'h1;
      address_valid_n_out = 1'h0;
      die_one_select_n_out = 1'h0;
      die_one_output_enable_n_out = 1'h0;
   endtask
   // returns just after the strobe rises, select, address and data still held
   task automatic write(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
      addr_out = a;
      dq_out = d;
      last_dq = d;
      die_one_output_enable_n_out = 1'h1;
      die_one_select_n_out = 1'h0;
      write_enable_n_out = 1'h0;
      repeat (4) @(posedge clock_in);
      #1;
      write_enable_n_out = 1'h1;
   endtask
   initial
   begin
      last_dq = DATA_RESET;
      idle();
      reset_n_out = 1'h1;
      write_protect_n_out = 1'h1;
      flash_clk_out = 1'h0;
      addr_out = ADDR_RESET;
   end
endmodule

// *** tb/tb_pfbc_bus_control.sv ***
// testbench: pin scenarios and array core side of the bus control
// assumes the host model drives the pins; core inputs come from here
module tb_pfbc_bus_control
   import pfbc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in, rst_in, sync_mode_in, read_data_valid_in, busy_in;
   logic leave_read_array_in, status_load_in, die_one_select_n_in;
   logic [CFG_W-1:0] read_config_reg_in;
   logic [DATA_W-1:0] read_data_in, dq_in, dq_out, write_data_out;
   logic [STAT_W-1:0] status_in, status_reg_out;
   logic [ADDR_W-1:0] addr_in, read_addr_out, write_addr_out;
   logic die_one_output_enable_n_in, write_enable_n_in, reset_n_in;
   logic address_valid_n_in, write_protect_n_in, flash_clk_in;
   logic dq_oe_out, wait_out, wait_oe_out, top_die_out;
   logic write_strobe_out, automation_reset_out, device_active_out;
   logic lockdown_enforce_out, read_array_mode_out;
   pfbc_op_e bus_op_out;
   int errors, comparisons, n;
   pfbc_host_model host_u (
      .clock_in,
      .die_one_select_n_out(die_one_select_n_in),
      .die_one_output_enable_n_out(die_one_output_enable_n_in),
      .write_enable_n_out(write_enable_n_in),
      .address_valid_n_out(address_valid_n_in),
      .reset_n_out(reset_n_in),
      .write_protect_n_out(write_protect_n_in),
      .flash_clk_out(flash_clk_in),
      .addr_out(addr_in),
      .dq_out(dq_in)
   );
   pfbc_bus_control dut_u (
      .clock_in, .rst_in, .die_one_select_n_in,
      .die_one_output_enable_n_in, .write_enable_n_in,
      .address_valid_n_in, .reset_n_in, .write_protect_n_in,
      .flash_clk_in, .addr_in, .dq_in, .dq_out, .dq_oe_out,
      .wait_out, .wait_oe_out, .sync_mode_in, .read_config_reg_in,
      .read_data_in, .read_data_valid_in, .busy_in,
      .leave_read_array_in, .status_load_in, .status_in,
      .read_addr_out, .top_die_out, .write_addr_out,
      .write_data_out, .write_strobe_out, .automation_reset_out,
      .device_active_out, .lockdown_enforce_out,
      .read_array_mode_out, .status_reg_out, .bus_op_out
   );
   initial
   begin
      clock_in = 1'h0;
      forever #4 clock_in = ~clock_in;
   end
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      comparisons++;
      if (act !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, act, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic count_strobes();
      n = 0;
      repeat (8)
      begin
         cyc(1);
         n += int'(write_strobe_out === 1'h1);
      end
      host_u.idle();
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic test_reset();
      chk(status_reg_out, 32'h80);
      chk(read_array_mode_out, 32'h1);
      chk(dq_oe_out, 32'h0);
      chk(wait_oe_out, 32'h0);
      $display("test_reset done");
   endtask
   task automatic test_read();
      read_data_in = 16'hA5C3;
      host_u.read_start(25'h1000010);
      cyc(3);
      chk(dq_oe_out, 32'h1);
      chk(dq_out, 32'hA5C3);
      chk(top_die_out, 32'h1);
      chk(32'(bus_op_out), 32'(PFBC_READ));
      chk(wait_oe_out, 32'h1);
      chk(wait_out, 32'h0);
      host_u.addr_out = 25'h0000020;
      cyc(3);
      chk(read_addr_out, 32'h20);
      chk(top_die_out, 32'h0);
      host_u.address_valid_n_out = 1'h1;
      cyc(1);
      host_u.addr_out = 25'h0000444;
      cyc(3);
      chk(read_addr_out, 32'h20);
      host_u.die_one_output_enable_n_out = 1'h1;
      cyc(3);
      chk(dq_oe_out, 32'h0);
      chk(wait_oe_out, 32'h0);
      host_u.die_one_output_enable_n_out = 1'h0;
      host_u.die_one_select_n_out = 1'h1;
      cyc(3);
      chk(dq_oe_out, 32'h0);
      chk(wait_oe_out, 32'h0);
      host_u.idle();
      $display("test_read done");
   endtask
   task automatic test_write();
      cyc(1);
      host_u.write(25'h0ABCDE, 16'h1234);
      chk(dq_oe_out, 32'h0);
      count_strobes();
      chk(n, 32'h1);
      if (n == 0)
         stop_test();
      chk(write_addr_out, 32'h0ABCDE);
      chk(write_data_out, 32'h1234);
      $display("test_write done");
   endtask
   task automatic test_sync();
      cyc(1);
      sync_mode_in = 1'h1;
      host_u.read_start(25'h0000055);
      cyc(1);
      host_u.flash_clk_out = 1'h1;
      cyc(2);
      host_u.flash_clk_out = 1'h0;
      cyc(2);
      host_u.addr_out = 25'h0000066;
      cyc(3);
      chk(read_addr_out, 32'h55);
      chk(wait_out, 32'h1);
      read_data_valid_in = 1'h1;
      cyc(1);
      chk(wait_out, 32'h0);
      read_config_reg_in = 16'h0000;
      read_data_valid_in = 1'h0;
      cyc(1);
      chk(wait_out, 32'h0);
      host_u.idle();
      sync_mode_in = 1'h0;
      read_config_reg_in = 16'h0400;
      $display("test_sync done");
   endtask
   task automatic test_pin_reset();
      leave_read_array_in = 1'h1;
      status_load_in = 1'h1;
      cyc(1);
      leave_read_array_in = 1'h0;
      status_load_in = 1'h0;
      cyc(1);
      chk(read_array_mode_out, 32'h0);
      chk(status_reg_out, 32'h0);
      host_u.reset_n_out = 1'h0;
      host_u.read_start(25'h0000001);
      cyc(3);
      chk(automation_reset_out, 32'h1);
      chk(dq_oe_out, 32'h0);
      chk(wait_oe_out, 32'h0);
      host_u.idle();
      cyc(1);
      host_u.write(25'h0000002, 16'h00FF);
      count_strobes();
      chk(n, 32'h0);
      host_u.reset_n_out = 1'h1;
      cyc(4);
      chk(read_array_mode_out, 32'h1);
      chk(status_reg_out, 32'h80);
      $display("test_pin_reset done");
   endtask
   task automatic test_active();
      busy_in = 1'h1;
      cyc(3);
      chk(device_active_out, 32'h1);
      busy_in = 1'h0;
      cyc(1);
      chk(device_active_out, 32'h0);
      host_u.write_protect_n_out = 1'h0;
      cyc(3);
      chk(lockdown_enforce_out, 32'h1);
      host_u.write_protect_n_out = 1'h1;
      cyc(3);
      chk(lockdown_enforce_out, 32'h0);
      $display("test_active done");
   endtask
   initial
   begin
      errors = 0;
      comparisons = 0;
      rst_in = 1'h1;
      sync_mode_in = 1'h0;
      read_config_reg_in = 16'h0400;
      read_data_in = 16'h0000;
      read_data_valid_in = 1'h0;
      busy_in = 1'h0;
      leave_read_array_in = 1'h0;
      status_load_in = 1'h0;
      status_in = 8'h00;
      cyc(20);
      rst_in = 1'h0;
      cyc(2);
      test_reset();
      test_read();
      test_write();
      test_sync();
      test_pin_reset();
      test_active();
      stop_test();
   end
endmodule
